/* File: ccsp_clock_ctrl.sv */
// Clock source selection, prescaler, oscillator start-up and write guard.
// How it works
// - fuse sets fast frequency, trims loaded
// - four read-only factory error bytes
// - error byte: signed, in parts per 1024
// - low-power oscillator gives 1.024 kHz tick
// - low-power ready after start plus four
// - crystal or pin clock per option bit
// - crystal enable overrides pins, gates running
// - crystal start-up wait chosen by field
// - pin-clock option: two-cycle start-up
// - external pin becomes input when requested
// - external clock ready after two cycles
// - key write opens four-instruction window
// - unguarded writes to guarded registers ignored
// - all control registers guarded, same key
// - source code selects fast/slow/crystal/external
// - divider codes map to documented ratios
// - prescaler off passes main clock undivided
// - reset: fast oscillator, divide by six
`timescale 1ns/1ps
module ccsp_clock_ctrl #(
   parameter logic [7:0] ERR16_LOW  = 8'h00, // Factory values, arbitrary defaults.
   parameter logic [7:0] ERR16_HIGH = 8'h00,
   parameter logic [7:0] ERR20_LOW  = 8'h00,
   parameter logic [7:0] ERR20_HIGH = 8'h00,
   parameter int XTAL_DLY0 = 256,
   parameter int XTAL_DLY1 = 1024,
   parameter int XTAL_DLY2 = 4096,
   parameter int XTAL_DLY3 = 16384
) (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire ccsp_pkg::ccsp_fuse_t fuse,
   input  wire logic               instrDone,
   input  wire logic               reqLowPower,
   input  wire logic               reqCrystal,
   input  wire logic               reqExternal,
   input  wire logic               lowPowerOscPin,
   input  wire logic               crystalPinA,
   input  wire logic               externalPinClock,
   output logic [1:0]              fastOscFreq,
   output logic                    mainClkEn,
   output logic                    perClkEn,
   output logic                    clockOutPin,
   output logic                    tick1k,
   output logic                    crystalPinsOverride,
   output logic                    extPinIsInput
);
   import ccsp_pkg::*;

   // ************************************************************
   // Reset release.
   // ************************************************************
   logic [1:0] rstSync_q;
   logic       rstn;

   // Asynchronous assert, release through two flops.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstn = rstSync_q[1];

   // ************************************************************
   // Pin inputs.
   // ************************************************************
   logic ulpLvl, ulpEdge, xtalLvl, xtalEdge, extLvl, extEdge;

   ccsp_pin_sync uUlpSync (.clk(clk), .rstn(rstn), .pinIn(lowPowerOscPin),
                           .level(ulpLvl), .rise(ulpEdge));
   ccsp_pin_sync uXtalSync (.clk(clk), .rstn(rstn), .pinIn(crystalPinA),
                            .level(xtalLvl), .rise(xtalEdge));
   ccsp_pin_sync uExtSync (.clk(clk), .rstn(rstn), .pinIn(externalPinClock),
                           .level(extLvl), .rise(extEdge));

   // ************************************************************
   // Register file and write guard.
   // ************************************************************
   logic [7:0]  source_q, source_d, divider_q, divider_d, fastCtl_q, fastCtl_d;
   logic [7:0]  center_q, center_d, temp_q, temp_d, slowCtl_q, slowCtl_d;
   logic [7:0]  xtalCtl_q, xtalCtl_d;
   logic        freeze_q, freeze_d, loaded_q, loaded_d;
   logic [1:0]  freq_q, freq_d;
   logic        guardOpen_q, guardOpen_d;
   logic [2:0]  guardCnt_q, guardCnt_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [9:0]  idx;
   logic        access, wrOk, calLocked;
   logic [7:0]  stateByte, rdByte;
   logic        mapped;

   assign idx    = paddr[11:2];
   assign access = psel && penable && !pready_q;
   // Guarded writes pass only inside an open window.
   assign wrOk   = access && pwrite && guardOpen_q;
   // Trims freeze by fuse, or by their lock bit while the fast source is selected.
   assign calLocked = fuse.lock || (temp_q[CAL_LOCK_BIT] && source_q[1:0] == 2'b00);

   // Read multiplexer; reserved bits read as zero.
   always_comb begin
      mapped = 1'b1;
      rdByte = 8'h00;
      case (idx)
         IDX_SOURCE:  rdByte = source_q;
         IDX_DIVIDER: rdByte = divider_q;
         IDX_FREEZE:  rdByte = {7'h00, freeze_q};
         IDX_STATE:   rdByte = stateByte;
         IDX_FASTCTL: rdByte = fastCtl_q;
         IDX_CENTER:  rdByte = center_q;
         IDX_TEMP:    rdByte = temp_q;
         IDX_SLOWCTL: rdByte = slowCtl_q;
         IDX_XTALCTL: rdByte = xtalCtl_q;
         IDX_ERR0:    rdByte = ERR16_LOW;
         IDX_ERR0 + 10'h001: rdByte = ERR16_HIGH;
         IDX_ERR0 + 10'h002: rdByte = ERR20_LOW;
         IDX_ERR0 + 10'h003: rdByte = ERR20_HIGH;
         IDX_GUARD:   rdByte = {7'h00, guardOpen_q};
         default:     mapped = 1'b0;
      endcase
   end

   // Next register values; writes to read-only bytes are dropped quietly.
   always_comb begin
      source_d = source_q;
      divider_d = divider_q;
      freeze_d = freeze_q;
      fastCtl_d = fastCtl_q;
      center_d = center_q;
      temp_d = temp_q;
      slowCtl_d = slowCtl_q;
      xtalCtl_d = xtalCtl_q;
      freq_d = freq_q;
      loaded_d = 1'b1;
      guardOpen_d = guardOpen_q;
      guardCnt_d = guardCnt_q;
      prdata_d = prdata_q;
      pready_d = access;
      pslverr_d = access && !mapped;
      if (access && !pwrite) begin
         prdata_d = {24'h000000, rdByte};
      end
      // Fuse values are caught on the first cycle after reset release.
      if (!loaded_q) begin
         freq_d   = fuse.freqChoice;
         center_d = {1'b0, fuse.centerTrim};
         temp_d   = {4'h0, fuse.tempTrim};
         freeze_d = fuse.lock;
      end else if (wrOk) begin
         case (idx)
            IDX_SOURCE:  if (!freeze_q) source_d = pwdata[7:0] & 8'h83;
            IDX_DIVIDER: if (!freeze_q) divider_d = pwdata[7:0] & 8'h1F;
            IDX_FREEZE:  if (!freeze_q) freeze_d = pwdata[0];
            IDX_FASTCTL: fastCtl_d = pwdata[7:0] & 8'h02;
            IDX_CENTER:  if (!calLocked) center_d = pwdata[7:0] & 8'h7F;
            IDX_TEMP:    if (!calLocked) temp_d = pwdata[7:0] & 8'h8F;
            IDX_SLOWCTL: slowCtl_d = pwdata[7:0] & 8'h02;
            IDX_XTALCTL: xtalCtl_d = pwdata[7:0] & 8'h37;
            default: ;
         endcase
      end
      // Window counts retired instructions and shuts after the fourth.
      if (guardOpen_q && instrDone) begin
         guardCnt_d = guardCnt_q + 3'h1;
         if (guardCnt_q == 3'(GUARD_INSTR - 1)) begin
            guardOpen_d = 1'b0;
         end
      end
      // A key write opens or reopens the window and wins over the close.
      if (access && pwrite && idx == IDX_GUARD && pwdata[7:0] == IO_UNLOCK_KEY) begin
         guardOpen_d = 1'b1;
         guardCnt_d  = 3'h0;
      end
   end

   // Reset values; the main clock starts on the fast source, the prescaler at divide by six.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         source_q    <= SOURCE_RST;
         divider_q   <= DIVIDER_RST;
         freeze_q    <= 1'b0;
         fastCtl_q   <= CTRL_RST;
         center_q    <= CTRL_RST;
         temp_q      <= CTRL_RST;
         slowCtl_q   <= CTRL_RST;
         xtalCtl_q   <= CTRL_RST;
         freq_q      <= 2'b00;
         loaded_q    <= 1'b0;
         guardOpen_q <= 1'b0;
         guardCnt_q  <= 3'h0;
         prdata_q    <= 32'h00000000;
         pready_q    <= 1'b0;
         pslverr_q   <= 1'b0;
      end else begin
         source_q    <= source_d;
         divider_q   <= divider_d;
         freeze_q    <= freeze_d;
         fastCtl_q   <= fastCtl_d;
         center_q    <= center_d;
         temp_q      <= temp_d;
         slowCtl_q   <= slowCtl_d;
         xtalCtl_q   <= xtalCtl_d;
         freq_q      <= freq_d;
         loaded_q    <= loaded_d;
         guardOpen_q <= guardOpen_d;
         guardCnt_q  <= guardCnt_d;
         prdata_q    <= prdata_d;
         pready_q    <= pready_d;
         pslverr_q   <= pslverr_d;
      end
   end

   // ************************************************************
   // Oscillator start-up.
   // ************************************************************
   logic        ulpReq, xtalReq, extReq;
   logic [11:0] ulpCyc_q, ulpCyc_d;
   logic [2:0]  ulpEdges_q, ulpEdges_d;
   logic        ulpRdy_q, ulpRdy_d;
   logic [15:0] xtalCnt_q, xtalCnt_d;
   logic        xtalRdy_q, xtalRdy_d;
   logic [1:0]  extCnt_q, extCnt_d;
   logic        extRdy_q, extRdy_d;
   logic [4:0]  tickCnt_q, tickCnt_d;
   logic        tick_q, tick_d;
   logic [15:0] xtalWait;

   assign ulpReq  = reqLowPower || slowCtl_q[RUN_BIT] || source_q[1:0] == 2'b01;
   // Crystal runs on request only when enabled.
   assign xtalReq = xtalCtl_q[XO_EN_BIT] &&
                    (reqCrystal || xtalCtl_q[RUN_BIT] || source_q[1:0] == 2'b10);
   assign extReq  = reqExternal || source_q[1:0] == 2'b11;

   // Pin-clock option ignores the delay field.
   always_comb begin
      xtalWait = 16'(XTAL_DLY0);
      if (xtalCtl_q[XO_SEL_BIT]) begin
         xtalWait = 16'(PIN_CLK_EDGES);
      end else begin
         case (xtalCtl_q[XO_DLY_LSB +: 2])
            2'b00: xtalWait = 16'(XTAL_DLY0);
            2'b01: xtalWait = 16'(XTAL_DLY1);
            2'b10: xtalWait = 16'(XTAL_DLY2);
            default: xtalWait = 16'(XTAL_DLY3 - 1);
         endcase
      end
   end

   // Start-up counters restart whenever a request goes away.
   always_comb begin
      ulpCyc_d = ulpCyc_q;
      ulpEdges_d = ulpEdges_q;
      ulpRdy_d = ulpRdy_q;
      xtalCnt_d = xtalCnt_q;
      xtalRdy_d = xtalRdy_q;
      extCnt_d = extCnt_q;
      extRdy_d = extRdy_q;
      tickCnt_d = tickCnt_q;
      tick_d = 1'b0;
      if (!ulpReq) begin
         ulpCyc_d = 12'h000;
         ulpEdges_d = 3'h0;
         ulpRdy_d = 1'b0;
      end else if (ulpCyc_q != 12'(ULP_START_CYC)) begin
         ulpCyc_d = ulpCyc_q + 12'h001;
      end else if (ulpEdge && !ulpRdy_q) begin
         ulpEdges_d = ulpEdges_q + 3'h1;
         ulpRdy_d = (ulpEdges_q == 3'(ULP_EXTRA_EDGES - 1));
      end
      if (ulpRdy_q && ulpEdge) begin
         tickCnt_d = tickCnt_q + 5'h01;
         tick_d = (tickCnt_q == 5'(ULP_TICK_DIV - 1));
      end
      if (!xtalReq) begin
         xtalCnt_d = 16'h0000;
         xtalRdy_d = 1'b0;
      end else if (xtalEdge && !xtalRdy_q) begin
         xtalCnt_d = xtalCnt_q + 16'h0001;
         xtalRdy_d = (xtalCnt_q == xtalWait - 16'h0001);
      end
      if (!extReq) begin
         extCnt_d = 2'h0;
         extRdy_d = 1'b0;
      end else if (extEdge && !extRdy_q) begin
         extCnt_d = extCnt_q + 2'h1;
         extRdy_d = (extCnt_q == 2'(PIN_CLK_EDGES - 1));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ulpCyc_q   <= 12'h000;
         ulpEdges_q <= 3'h0;
         ulpRdy_q   <= 1'b0;
         xtalCnt_q  <= 16'h0000;
         xtalRdy_q  <= 1'b0;
         extCnt_q   <= 2'h0;
         extRdy_q   <= 1'b0;
         tickCnt_q  <= 5'h00;
         tick_q     <= 1'b0;
      end else begin
         ulpCyc_q   <= ulpCyc_d;
         ulpEdges_q <= ulpEdges_d;
         ulpRdy_q   <= ulpRdy_d;
         xtalCnt_q  <= xtalCnt_d;
         xtalRdy_q  <= xtalRdy_d;
         extCnt_q   <= extCnt_d;
         extRdy_q   <= extRdy_d;
         tickCnt_q  <= tickCnt_d;
         tick_q     <= tick_d;
      end
   end

   // ************************************************************
   // Source switch and prescaler.
   // ************************************************************
   ccsp_sw_t   sw_q, sw_d;
   logic [1:0] active_q, active_d;
   logic [6:0] ratio_q, ratio_d;
   logic [6:0] newRatio;
   logic       srcTick, boundary, perTick, newReady;
   logic       mainEn_q, perEn_q, clkOut_q, tickOut_q, xtalOvr_q, extIn_q;

   // Active source produces the main clock enable.
   always_comb begin
      unique case (active_q)
         2'b00: srcTick = 1'b1;
         2'b01: srcTick = ulpEdge;
         2'b10: srcTick = xtalEdge;
         2'b11: srcTick = extEdge;
      endcase
      unique case (source_q[1:0])
         2'b00: newReady = 1'b1;
         2'b01: newReady = ulpRdy_q;
         2'b10: newReady = xtalRdy_q;
         2'b11: newReady = extRdy_q;
      endcase
      newRatio = divFromCode(divider_q[DIV_CODE_LSB +: 4]);
   end

   // Reserved codes keep the last good ratio; prescaler off means ratio one.
   always_comb begin
      ratio_d = ratio_q;
      if (!divider_q[DIV_ON_BIT]) begin
         ratio_d = 7'h01;
      end else if (newRatio != 7'h00) begin
         ratio_d = newRatio;
      end
   end

   // A pending source change waits for readiness and a period boundary.
   always_comb begin
      sw_d = sw_q;
      active_d = active_q;
      unique case (sw_q)
         SW_IDLE: if (source_q[1:0] != active_q) sw_d = SW_WAIT;
         SW_WAIT: begin
            if (source_q[1:0] == active_q) begin
               sw_d = SW_IDLE;
            end else if (newReady && boundary) begin
               active_d = source_q[1:0];
               sw_d = SW_IDLE;
            end
         end
      endcase
   end

   ccsp_per_div uDiv (.clk(clk), .rstn(rstn), .mainTick(srcTick), .divisor(ratio_q),
                      .perTick(perTick), .boundary(boundary));

   assign stateByte = {extRdy_q, xtalRdy_q, ulpRdy_q, 1'b1, 3'b000, sw_q == SW_WAIT};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_q      <= SW_IDLE;
         active_q  <= 2'b00;
         ratio_q   <= 7'h06;
         mainEn_q  <= 1'b0;
         perEn_q   <= 1'b0;
         clkOut_q  <= 1'b0;
         tickOut_q <= 1'b0;
         xtalOvr_q <= 1'b0;
         extIn_q   <= 1'b0;
      end else begin
         sw_q      <= sw_d;
         active_q  <= active_d;
         ratio_q   <= ratio_d;
         mainEn_q  <= srcTick;
         perEn_q   <= perTick;
         clkOut_q  <= perTick && source_q[SRC_OUT_BIT];
         tickOut_q <= tick_q;
         xtalOvr_q <= xtalCtl_q[XO_EN_BIT];
         extIn_q   <= extReq;
      end
   end

   // ************************************************************
   // Outputs, all from flops.
   // ************************************************************
   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign fastOscFreq         = freq_q;
   assign mainClkEn           = mainEn_q;
   assign perClkEn            = perEn_q;
   assign clockOutPin         = clkOut_q;
   assign tick1k              = tickOut_q;
   assign crystalPinsOverride = xtalOvr_q;
   assign extPinIsInput       = extIn_q;
endmodule

/* File: ccsp_clock_ctrl_chk.sv */
// Port-level assertions for the clock source and protect controller.
`timescale 1ns/1ps
module ccsp_clock_ctrl_chk (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire ccsp_pkg::ccsp_fuse_t fuse,
   input wire logic                 reqExternal,
   input wire logic [1:0]           fastOscFreq,
   input wire logic                 tick1k,
   input wire logic                 crystalPinsOverride,
   input wire logic                 extPinIsInput
);
   // One clock domain, so the raw reset disables every check.
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_answer_next: assert property (psel && penable && !pready |=> pready)
      else $error("transfer not answered one cycle after it was taken");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready stood for more than one cycle");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("error flag seen without ready");
   a_upper_zero: assert property (prdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   a_fuse_freq: assert property (resetn [*8] |-> fastOscFreq == fuse.freqChoice)
      else $error("fast oscillator frequency differs from fuse choice");
   a_pin_input: assert property (reqExternal [*2] |-> extPinIsInput)
      else $error("external pin not made an input on request");
   a_tick_gap: assert property (tick1k |=> !tick1k [*8])
      else $error("slow tick pulses too close together");
   // The override may only move as a consequence of a bus write just before.
   a_override_cause: assert property ($changed(crystalPinsOverride) |->
      $past(psel && penable && pwrite, 1) || $past(psel && penable && pwrite, 2))
      else $error("pin override changed without a write");
endmodule

bind ccsp_clock_ctrl ccsp_clock_ctrl_chk u_chk (.*);

/* File: ccsp_clock_ctrl_tb.sv */
// Self-checking bench for the clock source and protect controller.
`timescale 1ns/1ps
module ccsp_clock_ctrl_tb;
   import ccsp_pkg::*;
   localparam logic [7:0] EV[4] = '{8'h85, 8'h12, 8'hF0, 8'h7F};
   // Smallest target divisor that software may compensate, and the legal floor.
   localparam int TGT = 32'h0000004A, FLOOR = 32'h00000040;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, instrDone = 0, e;
   logic reqLowPower = 0, reqCrystal = 0, reqExternal = 0, lowPowerOscPin = 0;
   logic crystalPinA = 0, externalPinClock = 0, pready, pslverr, perClkEn, tick1k;
   logic crystalPinsOverride, extPinIsInput, mainClkEn, clockOutPin;
   logic [1:0] fastOscFreq;
   logic [7:0] m;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   ccsp_fuse_t fuse = '{2'h2, 7'h35, 4'h9, 1'b0};
   int err_count = 0, tests_run = 0, cyc = 0, cur = 6, n;
   int ratio[16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};
   // Short crystal waits keep the run brief.
   ccsp_clock_ctrl #(.ERR16_LOW(EV[0]), .ERR16_HIGH(EV[1]), .ERR20_LOW(EV[2]),
      .ERR20_HIGH(EV[3]), .XTAL_DLY0(4), .XTAL_DLY1(8), .XTAL_DLY2(16), .XTAL_DLY3(32))
      dut (.*);
   // Clock, and a free-running slow oscillator with a rising edge every 8 cycles.
   initial forever #20 clk = ~clk;
   initial forever begin
      repeat (4) @(posedge clk);
      lowPowerOscPin <= ~lowPowerOscPin;
   end
   // A hang is cut short well beyond the expected length of the run.
   always @(posedge clk) if (++cyc == 40000) begin
      err_count++;
      wrap_up();
   end
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      tests_run++;
      if (y !== x) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, x, y);
      end
   endtask
   // One bus transfer; the leading edge keeps back-to-back calls apart.
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
      @(posedge clk) penable <= 1;
      while (pready !== 1'b1) @(posedge clk);
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      bus(0, a, 0);
      chk("read data", {24'h0, x}, r);
   endtask
   task automatic instr(input int k);
      repeat (k) begin
         @(posedge clk) instrDone <= 1;
         @(posedge clk) instrDone <= 0;
      end
   endtask
   // Unlocked write; four instructions afterwards close the window again.
   task automatic gw(input logic [11:0] a, input logic [7:0] d);
      bus(1, 12'h0C0, IO_UNLOCK_KEY);
      bus(1, a, d);
      instr(4);
   endtask
   // Cycles to the next pulse: 0 peripheral, 1 slow tick, 2 main clock enable.
   task automatic gap(input int t);
      n = 1;
      do @(posedge clk);
      while ((t == 1 ? tick1k : t == 2 ? mainClkEn : perClkEn) !== 1'b1 && ++n < 5000);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h71B4));
      repeat (8) @(posedge clk);
      resetn <= 1;
      reqLowPower <= 1;
      repeat (6) @(posedge clk);
      chk("fast freq", fuse.freqChoice, fastOscFreq);
      rd(12'h004, 8'h11);
      rd(12'h044, fuse.centerTrim);
      rd(12'h048, fuse.tempTrim);
      for (int i = 0; i < 4; i++) begin
         rd(12'h080 + 12'(4 * i), EV[i]);
         // Software compensation of the smallest target, worked from the byte read.
         n = TGT * (1024 + int'($signed(r[7:0]))) / 1024;
         chk("comp divisor", 32'(TGT * (1024 + int'($signed(EV[i]))) / 1024), 32'(n));
         chk("divisor floor", 1, 32'(n >= FLOOR));
      end
      bus(0, 12'hFFC, 0);
      chk("error flag", 1, e);
      repeat (3) gap(0);
      chk("period", 6, n);
      $display("reset test done");
      m = 8'($urandom % 128);
      gw(12'h044, m);
      bus(1, 12'h044, ~m);
      rd(12'h044, m);
      bus(1, 12'h0C0, IO_UNLOCK_KEY);
      instr(3);
      bus(1, 12'h004, 8'h01);
      instr(1);
      rd(12'h004, 8'h01);
      bus(1, 12'h0C0, IO_UNLOCK_KEY);
      instr(4);
      bus(1, 12'h004, 8'h11);
      rd(12'h004, 8'h01);
      $display("guard test done");
      for (int c = 0; c < 17; c++) begin
         cur = (c == 16) ? 1 : (ratio[c] != 0) ? ratio[c] : cur;
         gw(12'h004, (c == 16) ? 8'h18 : {3'h0, 4'(c), 1'b1});
         repeat (3) gap(0);
         chk("period", cur, n);
      end
      $display("divider test done");
      gw(12'h070, 8'h05);
      chk("pin override", 1, crystalPinsOverride);
      {reqCrystal, reqExternal} <= 2'b11;
      for (int k = 0; k < 2; k++) begin
         repeat (3) @(posedge clk);
         {crystalPinA, externalPinClock} <= 2'b11;
         repeat (3) @(posedge clk);
         {crystalPinA, externalPinClock} <= 2'b00;
         repeat (8) @(posedge clk);
         bus(0, 12'h00C, 0);
         chk("started", k ? 3 : 0, r[7:6]);
      end
      chk("pin input", 1, extPinIsInput);
      gap(1);
      gap(1);
      chk("tick gap", 256, n);
      bus(0, 12'h00C, 0);
      chk("slow ready", 1, r[5]);
      // Main clock from the slow oscillator, undivided, mirrored on the output pin.
      gw(12'h000, 8'h81);
      rd(12'h00C, 8'hF0);
      repeat (3) gap(2);
      chk("main period", 8, n);
      repeat (2) gap(0);
      chk("out period", 8, n);
      chk("clock out", 1, clockOutPin);
      $display("source test done");
      wrap_up();
   end
endmodule

/* File: ccsp_per_div.sv */
// Peripheral clock divider that takes a new ratio only at a period boundary.
`timescale 1ns/1ps
module ccsp_per_div (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       mainTick,
   input  wire logic [6:0] divisor,
   output logic            perTick,
   output logic            boundary
);
   logic [6:0] cnt_q, cnt_d;
   logic [6:0] div_q, div_d;
   logic       tick_q, tick_d;

   // Reloading the ratio only at wrap keeps every period whole.
   always_comb begin
      cnt_d    = cnt_q;
      div_d    = div_q;
      boundary = mainTick && (cnt_q >= div_q - 7'h01);
      tick_d   = boundary;
      if (boundary) begin
         cnt_d = 7'h00;
         div_d = divisor;
      end else if (mainTick) begin
         cnt_d = cnt_q + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= 7'h00;
         div_q  <= 7'h06;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   assign perTick = tick_q;
endmodule

/* File: ccsp_pin_sync.sv */
// Three-flop pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module ccsp_pin_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic pinIn,
   output logic      level,
   output logic      rise
);
   logic [2:0] sync_q, sync_d;
   logic       level_q, level_d;
   logic       rise_q, rise_d;

   // A change counts only once the second and third flops agree.
   always_comb begin
      sync_d  = {sync_q[1:0], pinIn};
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
      rise_d  = level_d & ~level_q;
   end

   // Only the second flop reads the first.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_q  <= 3'h0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
      end else begin
         sync_q  <= sync_d;
         level_q <= level_d;
         rise_q  <= rise_d;
      end
   end

   assign level = level_q;
   assign rise  = rise_q;
endmodule

/* File: ccsp_pkg.sv */
// Shared constants, types and helpers of the clock source and protect controller.
package ccsp_pkg;

   // ************************************************************
   // Register indices (byte address is four times the index).
   // ************************************************************
   localparam logic [9:0] IDX_SOURCE  = 10'h000;
   localparam logic [9:0] IDX_DIVIDER = 10'h001;
   localparam logic [9:0] IDX_FREEZE  = 10'h002;
   localparam logic [9:0] IDX_STATE   = 10'h003;
   localparam logic [9:0] IDX_FASTCTL = 10'h010;
   localparam logic [9:0] IDX_CENTER  = 10'h011;
   localparam logic [9:0] IDX_TEMP    = 10'h012;
   localparam logic [9:0] IDX_SLOWCTL = 10'h018;
   localparam logic [9:0] IDX_XTALCTL = 10'h01C;
   localparam logic [9:0] IDX_ERR0    = 10'h020;
   localparam logic [9:0] IDX_GUARD   = 10'h030;

   // ************************************************************
   // Reset values and field positions.
   // ************************************************************
   localparam logic [7:0] SOURCE_RST  = 8'h00;
   localparam logic [7:0] DIVIDER_RST = 8'h11;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam int SRC_OUT_BIT  = 7;
   localparam int DIV_ON_BIT   = 0;
   localparam int DIV_CODE_LSB = 1;
   localparam int RUN_BIT      = 1;
   localparam int XO_EN_BIT    = 0;
   localparam int XO_SEL_BIT   = 2;
   localparam int XO_DLY_LSB   = 4;
   localparam int CAL_LOCK_BIT = 7;
   localparam logic [7:0] IO_UNLOCK_KEY = 8'h5A;

   // ************************************************************
   // Timing counts.
   // ************************************************************
   localparam int CLK_PERIOD_NS   = 40;
   localparam int ULP_START_NS    = 100000;
   localparam int ULP_START_CYC   = (ULP_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ULP_EXTRA_EDGES = 4;
   localparam int PIN_CLK_EDGES   = 2;
   localparam int ULP_TICK_DIV    = 32;
   localparam int GUARD_INSTR     = 4;

   // ************************************************************
   // Types.
   // ************************************************************
   typedef struct packed {
      logic [1:0] freqChoice;
      logic [6:0] centerTrim;
      logic [3:0] tempTrim;
      logic       lock;
   } ccsp_fuse_t;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b01,
      SW_WAIT = 2'b10
   } ccsp_sw_t;

   // Divide ratio for a divider code; zero marks a reserved code.
   function automatic logic [6:0] divFromCode(input logic [3:0] code);
      logic [6:0] r;
      r = 7'h00;
      case (code)
         4'h0: r = 7'h02;
         4'h1: r = 7'h04;
         4'h2: r = 7'h08;
         4'h3: r = 7'h10;
         4'h4: r = 7'h20;
         4'h5: r = 7'h40;
         4'h8: r = 7'h06;
         4'h9: r = 7'h0A;
         4'hA: r = 7'h0C;
         4'hB: r = 7'h18;
         4'hC: r = 7'h30;
         default: r = 7'h00;
      endcase
      return r;
   endfunction

endpackage
